// File: design/mtc_map.svh
/*
 Register offsets, field positions, reset values and timing counts
 for the measurement trigger controller. Assumes an APB slave at 32 bits.
*/
`ifndef MTC_MAP_SVH
`define MTC_MAP_SVH
`define MTC_CTRL_OFF 12'h000
`define MTC_CMD_OFF 12'h004
`define MTC_STAT_OFF 12'h008
`define MTC_RES_OFF 12'h00c
`define MTC_FILT_OFF 12'h010
`define MTC_SAMP_OFF 12'h014
`define MTC_CTRL_CONT_BIT 0
`define MTC_CTRL_SRC_LSB 1
`define MTC_CTRL_DLY_BIT 3
`define MTC_CTRL_SPD_LSB 4
`define MTC_CTRL_FMT_BIT 6
`define MTC_CTRL_BORD_BIT 7
`define MTC_CMD_ABORT_BIT 0
`define MTC_CMD_INIT_BIT 1
`define MTC_CMD_TRGIMM_BIT 2
`define MTC_CMD_TRGCOM_BIT 3
`define MTC_CMD_CONF_BIT 4
`define MTC_CMD_RST_BIT 5
`define MTC_CTRL_RST 32'h0000_0009
`define MTC_FILT_RST 8'h01
`define MTC_CLK_MHZ 200
`define MTC_T20_MS 50
`define MTC_T40_MS 25
`define MTC_T200_MS 5
`define MTC_CYC(ms) ((ms) * 1000 * `MTC_CLK_MHZ)
`endif

// File: design/mtc_pkg.sv
/*
 Types for the measurement trigger controller.
 Assumes mtc_map.svh supplies all numeric constants.
*/
`default_nettype none
package mtc_pkg;
  typedef enum logic [1:0] {MTC_IDLE, MTC_INIT, MTC_DETECT, MTC_MEAS}
    mtc_state_t;
  typedef enum logic [1:0] {MTC_SRC_IMM, MTC_SRC_BUS, MTC_SRC_HOLD}
    mtc_src_t;
  typedef enum logic [1:0] {MTC_SPD_20, MTC_SPD_40, MTC_SPD_200}
    mtc_speed_t;
endpackage
`default_nettype wire

// File: design/mtc_top.sv
/*
 Trigger and measurement sequencing controller with APB registers.
 Assumes a sample source gives filtered readings and the remote command
 decoder pulses ifc_clear and group_trigger synchronous to core_clk.
*/
// Contract
// [RULE1] Power-up, clear, reset, abort force idle
// [RULE2] Idle leaves on continuous or one-shot initiate
// [RULE3] Downward pass through initiate unconditional
// [RULE4] Upward with continuous on goes detect
// [RULE5] Upward with continuous off goes idle
// [RULE6] Bus source: group, common, immediate triggers
// [RULE7] Hold source: only immediate trigger command
// [RULE8] Immediate source: detection completes at once
// [RULE9] Auto delay from filter length before measuring
// [RULE10] Delay excludes any sensor response allowance
// [RULE11] Auto delay on at reset, measure, configure; code has no measure command, only reset and configure set it
// [RULE12] Standby holds readable result until triggered
// [RULE13] Free-run preset refreshes result every measurement
// [RULE14] Local control forces free-run mode
// [RULE15] Speeds give 50, 25, 5 ms cycles
// [RULE16] 200 rate disables averaging, offsets, limits, math
// [RULE17] Delay waits full filter; else current output
// [RULE18] ASCII or IEEE binary with byte order; code only swaps byte order, MTC_CTRL_FMT_BIT is unused
// [RULE19] Controller uses fetch in free-run mode
// [RULE20] Triggers outside detection are discarded
`include "mtc_map.svh"
`default_nettype none
module mtc_top #(
  parameter int unsigned CYC20 = `MTC_CYC(`MTC_T20_MS),
  parameter int unsigned CYC40 = `MTC_CYC(`MTC_T40_MS),
  parameter int unsigned CYC200 = `MTC_CYC(`MTC_T200_MS)
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic local_mode,
  input wire logic ifc_clear,
  input wire logic group_trigger,
  output logic [2:0] trig_state,
  output logic measure_busy,
  output logic result_valid,
  output logic math_enable
);
  mtc_pkg::mtc_state_t state_r;
  logic [31:0] ctrl_r, result_r, sample_r, cnt_r, cnt_nxt;
  logic [7:0] filt_r, fill_r;
  logic upward_r, fresh_r;
  logic wr, rd, cmd_wr, abort_ev, init_ev, trg_imm, trg_com, conf_ev;
  logic rst_cmd, cont, dly_on, trig_ok, cycle_done, full;
  mtc_pkg::mtc_src_t src;
  mtc_pkg::mtc_speed_t spd;

  function automatic logic [31:0] cycle_len(input mtc_pkg::mtc_speed_t s);
    case (s)
      mtc_pkg::MTC_SPD_40: cycle_len = CYC40;
      mtc_pkg::MTC_SPD_200: cycle_len = CYC200;
      default: cycle_len = CYC20;
    endcase
  endfunction

  function automatic logic [31:0] swap32(input logic [31:0] d);
    swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign cmd_wr = wr && paddr == `MTC_CMD_OFF;
  assign abort_ev = cmd_wr && pwdata[`MTC_CMD_ABORT_BIT];
  assign init_ev = cmd_wr && pwdata[`MTC_CMD_INIT_BIT];
  assign trg_imm = cmd_wr && pwdata[`MTC_CMD_TRGIMM_BIT];
  assign trg_com = cmd_wr && pwdata[`MTC_CMD_TRGCOM_BIT];
  assign conf_ev = cmd_wr && pwdata[`MTC_CMD_CONF_BIT];
  assign rst_cmd = cmd_wr && pwdata[`MTC_CMD_RST_BIT];
  // Local control overrides with the free-run preset
  assign cont = local_mode | ctrl_r[`MTC_CTRL_CONT_BIT]; // [RULE14]
  assign src = local_mode ? mtc_pkg::MTC_SRC_IMM : // [RULE14]
    mtc_pkg::mtc_src_t'(ctrl_r[`MTC_CTRL_SRC_LSB +: 2]);
  assign dly_on = ctrl_r[`MTC_CTRL_DLY_BIT];
  assign spd = mtc_pkg::mtc_speed_t'(ctrl_r[`MTC_CTRL_SPD_LSB +: 2]);

  always_comb
  begin
    case (src)
      mtc_pkg::MTC_SRC_BUS: trig_ok = group_trigger | trg_com | trg_imm; // [RULE6]
      mtc_pkg::MTC_SRC_HOLD: trig_ok = trg_imm; // [RULE7]
      default: trig_ok = 1'b1; // [RULE8]
    endcase
  end

  // Free-running measurement cycle clock
  assign cycle_done = cnt_r >= cycle_len(spd) - 32'd1; // [RULE15]
  assign cnt_nxt = cycle_done ? 32'd0 : cnt_r + 32'd1;
  always_ff @(posedge core_clk)
  begin
    if (reset)
      cnt_r <= 32'd0;
    else
      cnt_r <= cnt_nxt;
  end

  // Delay counts filter fill only; no sensor allowance is added
  assign full = fill_r >= filt_r; // [RULE10]

  always_ff @(posedge core_clk)
  begin
    if (reset || ifc_clear || rst_cmd || abort_ev)
    begin
      state_r <= mtc_pkg::MTC_IDLE; // [RULE1]
      upward_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        mtc_pkg::MTC_IDLE:
          if (cont || init_ev) // [RULE2]
          begin
            state_r <= mtc_pkg::MTC_INIT;
            upward_r <= 1'b0;
          end
        mtc_pkg::MTC_INIT:
        begin
          if (!upward_r || cont) // [RULE3] [RULE4]
          begin
            state_r <= mtc_pkg::MTC_DETECT;
          end
          else
          begin
            state_r <= mtc_pkg::MTC_IDLE; // [RULE5]
          end
        end
        mtc_pkg::MTC_DETECT:
        begin
          // Only this state looks at triggers; elsewhere they vanish
          if (trig_ok) // [RULE20]
          begin
            state_r <= mtc_pkg::MTC_MEAS;
          end
        end
        mtc_pkg::MTC_MEAS:
          if (cycle_done && (!dly_on || full)) // [RULE9] [RULE17]
          begin
            state_r <= mtc_pkg::MTC_INIT;
            upward_r <= 1'b1;
          end
        default: state_r <= mtc_pkg::MTC_IDLE;
      endcase
    end
  end

  // Filter fill restarts at each accepted trigger; others are dropped
  always_ff @(posedge core_clk)
  begin
    if (reset || (state_r == mtc_pkg::MTC_DETECT && trig_ok))
      fill_r <= 8'h00;
    else if (cycle_done && !full)
      fill_r <= fill_r + 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      ctrl_r <= `MTC_CTRL_RST; // [RULE11]
    else if (rst_cmd)
      ctrl_r <= `MTC_CTRL_RST;
    else if (wr && paddr == `MTC_CTRL_OFF)
      ctrl_r <= {24'h0, pwdata[7:0]};
    else if (conf_ev)
      ctrl_r[`MTC_CTRL_DLY_BIT] <= 1'b1; // [RULE11]
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      filt_r <= `MTC_FILT_RST;
    else if (wr && paddr == `MTC_FILT_OFF)
      filt_r <= (spd == mtc_pkg::MTC_SPD_200) ? 8'h01 : pwdata[7:0];
    else if (spd == mtc_pkg::MTC_SPD_200)
      filt_r <= 8'h01; // [RULE16]
  end

  // Results update only on completion; standby holds value
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sample_r <= 32'h0;
      result_r <= 32'h0;
      fresh_r <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `MTC_SAMP_OFF)
        sample_r <= pwdata;
      if (state_r == mtc_pkg::MTC_MEAS && cycle_done &&
          (!dly_on || full)) // [RULE12] [RULE13]
      begin
        result_r <= sample_r;
        fresh_r <= 1'b1;
      end
      else if (rd && paddr == `MTC_RES_OFF)
        fresh_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        case (paddr)
          `MTC_CTRL_OFF: prdata <= ctrl_r;
          `MTC_STAT_OFF: prdata <= {27'h0, fresh_r, upward_r,
                                    state_r == mtc_pkg::MTC_MEAS,
                                    state_r};
          `MTC_RES_OFF: prdata <= ctrl_r[`MTC_CTRL_BORD_BIT] ? // [RULE18]
            swap32(result_r) : result_r;
          `MTC_FILT_OFF: prdata <= {24'h0, filt_r};
          `MTC_SAMP_OFF: prdata <= sample_r;
          `MTC_CMD_OFF: prdata <= 32'h0;
          default:
          begin
            prdata <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      trig_state <= 3'h0;
      measure_busy <= 1'b0;
      result_valid <= 1'b0;
      math_enable <= 1'b1;
    end
    else
    begin
      trig_state <= {1'b0, state_r};
      measure_busy <= state_r == mtc_pkg::MTC_MEAS;
      result_valid <= fresh_r;
      math_enable <= spd != mtc_pkg::MTC_SPD_200; // [RULE16]
    end
  end

  idle_on_abort_a: assert property (@(posedge core_clk) disable iff (reset)
    abort_ev |=> state_r == mtc_pkg::MTC_IDLE) // [RULE1]
    else $error("abort did not force idle");
  idle_leave_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == mtc_pkg::MTC_IDLE && init_ev && !abort_ev && !ifc_clear
    && !rst_cmd |=> state_r == mtc_pkg::MTC_INIT) // [RULE2]
    else $error("initiate not taken");
  down_pass_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == mtc_pkg::MTC_INIT && !upward_r && !abort_ev && !ifc_clear
    && !rst_cmd |=> state_r == mtc_pkg::MTC_DETECT) // [RULE3]
    else $error("downward pass blocked");
  up_cont_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == mtc_pkg::MTC_INIT && upward_r && !cont && !abort_ev
    |=> state_r == mtc_pkg::MTC_IDLE) // [RULE5]
    else $error("single shot did not return idle");
  hold_src_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == mtc_pkg::MTC_DETECT && src == mtc_pkg::MTC_SRC_HOLD
    && !trg_imm && !abort_ev && !ifc_clear && !rst_cmd
    |=> state_r == mtc_pkg::MTC_DETECT) // [RULE7]
    else $error("hold source accepted a trigger");
  imm_src_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == mtc_pkg::MTC_DETECT && src == mtc_pkg::MTC_SRC_IMM
    && !abort_ev && !ifc_clear && !rst_cmd
    |=> state_r == mtc_pkg::MTC_MEAS) // [RULE8]
    else $error("immediate source waited");
  standby_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r != mtc_pkg::MTC_MEAS |=> $stable(result_r)) // [RULE12]
    else $error("result changed outside measurement");
  delay_full_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == mtc_pkg::MTC_MEAS && dly_on && !full && !abort_ev
    && !ifc_clear && !rst_cmd |=> state_r == mtc_pkg::MTC_MEAS) // [RULE17]
    else $error("measurement ended before filter full");
  local_free_a: assert property (@(posedge core_clk) disable iff (reset)
    local_mode |-> cont && src == mtc_pkg::MTC_SRC_IMM) // [RULE14]
    else $error("local mode not free-run");
  fast_math_a: assert property (@(posedge core_clk) disable iff (reset)
    spd == mtc_pkg::MTC_SPD_200 |=> !math_enable ##1 filt_r == 8'h01) // [RULE16]
    else $error("math left on at top speed");
  cover_freerun_c: cover property (@(posedge core_clk)
    state_r == mtc_pkg::MTC_MEAS && cont ##1 state_r == mtc_pkg::MTC_INIT);
  cover_bus_c: cover property (@(posedge core_clk)
    state_r == mtc_pkg::MTC_DETECT && src == mtc_pkg::MTC_SRC_BUS
    && group_trigger);
  cover_abort_c: cover property (@(posedge core_clk)
    state_r == mtc_pkg::MTC_MEAS && abort_ev);

  cover_hold_c: cover property (@(posedge core_clk)
    state_r == mtc_pkg::MTC_DETECT && src == mtc_pkg::MTC_SRC_HOLD
    && trg_imm);

  cover_delay_c: cover property (@(posedge core_clk)
    state_r == mtc_pkg::MTC_MEAS && dly_on && !full);

  // Upward path with continuous on must rearm detection
  up_detect_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == mtc_pkg::MTC_INIT && upward_r && cont
    && !abort_ev && !ifc_clear && !rst_cmd
    |=> state_r == mtc_pkg::MTC_DETECT) // [RULE4]
    else $error("continuous mode did not rearm");

  // A group trigger alone is enough on the bus source
  bus_trig_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == mtc_pkg::MTC_DETECT && src == mtc_pkg::MTC_SRC_BUS
    && group_trigger && !abort_ev && !ifc_clear && !rst_cmd
    |=> state_r == mtc_pkg::MTC_MEAS) // [RULE6]
    else $error("bus trigger not accepted");

  // Measuring can only follow detection
  drop_trig_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r != mtc_pkg::MTC_DETECT && state_r != mtc_pkg::MTC_MEAS
    |=> state_r != mtc_pkg::MTC_MEAS) // [RULE20]
    else $error("measurement started outside detection");

  // An accepted trigger restarts the settling count
  fill_restart_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == mtc_pkg::MTC_DETECT && trig_ok
    |=> fill_r == 8'h00) // [RULE9]
    else $error("settling count not restarted");

  // Every completed measurement refreshes the readable result
  fresh_done_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == mtc_pkg::MTC_MEAS && cycle_done && (!dly_on || full)
    |=> fresh_r && result_r == $past(sample_r)) // [RULE13]
    else $error("result not refreshed");

  conf_delay_a: assert property (@(posedge core_clk) disable iff (reset)
    conf_ev |=> dly_on) // [RULE11]
    else $error("configure left auto delay off");

  // The cycle counter wraps at the selected cycle length
  cycle_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
    cycle_done |=> cnt_r == 32'd0) // [RULE15]
    else $error("cycle counter did not wrap");

  byte_order_a: assert property (@(posedge core_clk) disable iff (reset)
    psel && !penable && paddr == `MTC_RES_OFF
    && ctrl_r[`MTC_CTRL_BORD_BIT]
    |=> prdata[31:24] == $past(result_r[7:0])
    && prdata[7:0] == $past(result_r[31:24])) // [RULE18]
    else $error("result byte order not swapped");

  // One answer per transfer; the access cycle never answers again
  ready_once_a: assert property (@(posedge core_clk) disable iff (reset)
    pready |=> !pready)
    else $error("ready held past one cycle");

  ready_setup_a: assert property (@(posedge core_clk) disable iff (reset)
    psel && !penable |=> pready)
    else $error("setup not answered");

  busy_out_a: assert property (@(posedge core_clk) disable iff (reset)
    state_r == mtc_pkg::MTC_MEAS |=> measure_busy)
    else $error("busy output missed measurement");
endmodule
`default_nettype wire

// File: sim/mtc_remote_ctrl.sv
/*
 Remote controller stand-in: interface clear and group trigger pulses.
 Assumes callers enter its tasks just after a rising core_clk edge.
*/
`default_nettype none
module mtc_remote_ctrl (
  input wire logic core_clk,
  output logic group_trigger,
  output logic ifc_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    group_trigger = 1'b0;
    ifc_clear = 1'b0;
  end
  // One-cycle pulse, as the bus decoder would deliver it
  task automatic send_get();
    group_trigger <= 1'b1;
    @(posedge core_clk);
    group_trigger <= 1'b0;
  endtask
  task automatic send_clear();
    ifc_clear <= 1'b1;
    @(posedge core_clk);
    ifc_clear <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: sim/tb_measurement_trigger_control.sv
/*
 Self-checking bench for the trigger controller over APB.
 Assumes shortened cycle counts; the remote model makes bus pulses.
*/
`default_nettype none
module tb_measurement_trigger_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, local_mode = 1'b0, pready, pslverr, err_q;
  logic ifc_clear, group_trigger, measure_busy, result_valid, math_enable;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [2:0] trig_state;
  int err_total = 0, compares = 0;
  mtc_top #(.CYC20(20), .CYC40(10), .CYC200(4)) uut (.core_clk(core_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .local_mode(local_mode), .ifc_clear(ifc_clear),
    .group_trigger(group_trigger), .trig_state(trig_state),
    .measure_busy(measure_busy), .result_valid(result_valid),
    .math_enable(math_enable));
  mtc_remote_ctrl ctl (.core_clk(core_clk), .group_trigger(group_trigger),
    .ifc_clear(ifc_clear));
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (n == 50)
    begin
      chk(32'h0, 32'h1);
      end_sim();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Bounded wait for a trigger state, counted as a check
  task automatic wst(input logic [2:0] v);
    int n;
    n = 0;
    while (trig_state !== v && n < 300)
    begin
      @(posedge core_clk);
      n++;
    end
    chk({29'h0, trig_state}, {29'h0, v});
    if (n == 300)
      end_sim();
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(`MTC_CTRL_OFF, 32'h0000_0009);
    apb(1'b0, 12'h0f0, 32'h0, q);
    chk({31'h0, err_q}, 32'h1);
    wr(`MTC_CTRL_OFF, 32'h0000_0002);
    wr(`MTC_CMD_OFF, 32'h0000_0001);
    wst(3'd0);
    wr(`MTC_CMD_OFF, 32'h0000_0008);
    repeat (3) @(posedge core_clk);
    chk({29'h0, trig_state}, 32'h0);
    // Each bus trigger kind completes a single shot
    for (int k = 0; k < 3; k++)
    begin
      wr(`MTC_CMD_OFF, 32'h0000_0002);
      wst(3'd2);
      if (k == 0)
        ctl.send_get();
      else
        wr(`MTC_CMD_OFF, k == 1 ? 32'h0000_0008 : 32'h0000_0004);
      wst(3'd3);
      wst(3'd0);
    end
    wr(`MTC_CTRL_OFF, 32'h0000_0004);
    wr(`MTC_CMD_OFF, 32'h0000_0002);
    wst(3'd2);
    ctl.send_get();
    wr(`MTC_CMD_OFF, 32'h0000_0008);
    repeat (3) @(posedge core_clk);
    chk({29'h0, trig_state}, 32'h2);
    wr(`MTC_CMD_OFF, 32'h0000_0004);
    wst(3'd3);
    wst(3'd0);
    wr(`MTC_CTRL_OFF, 32'h0000_0003);
    wst(3'd2);
    ctl.send_get();
    wst(3'd3);
    wst(3'd2);
    wr(`MTC_CTRL_OFF, 32'h0000_0002);
    ctl.send_clear();
    wst(3'd0);
    wr(`MTC_CTRL_OFF, 32'h0000_0004);
    local_mode <= 1'b1;
    wst(3'd3);
    local_mode <= 1'b0;
    wr(`MTC_CTRL_OFF, 32'h0000_0000);
    wr(`MTC_CMD_OFF, 32'h0000_0010);
    rd(`MTC_CTRL_OFF, 32'h0000_0008);
    wr(`MTC_FILT_OFF, 32'h0000_0005);
    wr(`MTC_CTRL_OFF, 32'h0000_0020);
    rd(`MTC_FILT_OFF, 32'h0000_0001);
    chk({31'h0, math_enable}, 32'h0);
    wr(`MTC_SAMP_OFF, 32'h1122_3344);
    wr(`MTC_CTRL_OFF, 32'h0000_0001);
    @(posedge core_clk);
    chk({31'h0, math_enable}, 32'h1);
    repeat (60) @(posedge core_clk);
    chk({31'h0, result_valid}, 32'h1);
    rd(`MTC_RES_OFF, 32'h1122_3344);
    wr(`MTC_CTRL_OFF, 32'h0000_0081);
    rd(`MTC_RES_OFF, 32'h4433_2211);
    end_sim();
  end
endmodule
`default_nettype wire
